/* File: src/motor_drive_regs.svh */
// Register map, field positions, reset values and timing counts of the motor drive
`ifndef MOTOR_DRIVE_REGS_SVH
`define MOTOR_DRIVE_REGS_SVH

// Byte offsets on the register bus
`define OFS_CTRL 8'h00
`define OFS_SPEED 8'h04
`define OFS_THRESH 8'h08
`define OFS_CAP 8'h0C
`define OFS_STATUS 8'h10

// Control register fields
`define CTRL_STOP_BIT 0
`define CTRL_REV_BIT 1

// Threshold register fields
`define THR_ZERO_LSB 0
`define THR_FULL_LSB 8

// Status register fields
`define ST_UV_BIT 0
`define ST_OT_BIT 1
`define ST_ILIM_BIT 2
`define ST_HALL_LSB 3
`define ST_FG1_BIT 6
`define ST_FG2_BIT 7
`define ST_SRC_LSB 8
`define ST_SNK_LSB 11

// Reset values
`define RST_CTRL 2'h3
`define RST_SPEED 8'h00
`define RST_ZERO 8'h10
`define RST_FULL 8'hF0
`define RST_CAP_PF 16'h0514

// Timing
`define CLK_HZ 25000000
`define CLK_PERIOD_NS 40
`define HALL_FILT_NS 1000
`define HALL_FILT_CYC ((`HALL_FILT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OSC_NUM 197
`define OSC_STEP_PER_TICK (64'd10000000000 / `CLK_HZ)
`define PWM_STEPS 256

`endif

/* File: src/motor_drive_pkg.sv */
// Shared types of the motor drive
package motor_drive_pkg;

	// One-hot phase gate pattern, source and sink side
	typedef struct packed {
		logic [2:0] src;
		logic [2:0] snk;
	} phase_drive_s;

	// Protection conditions
	typedef struct packed {
		logic uv;
		logic ot;
		logic ilim;
	} fault_s;

	// Speed pulse pair
	typedef struct packed {
		logic single_rate;
		logic triple_rate;
	} speed_pulse_s;

endpackage : motor_drive_pkg

/* File: src/bldc_direct_pwm_drive_control.sv */
// Direct PWM three-phase brushless drive control with Wishbone registers
//
// What this block does
// - PWM gates only source-side transistors
// - Duty spans zero to full on
// - PWM rate from timing capacitance formula
// - Undervoltage forces source side off
// - Overtemperature forces source side off
// - Current trip chops source side each period
// - Hall inputs get clean hysteretic levels
// - Single-rate pulse follows first Hall input
// - Triple-rate pulse combines all three Halls
// - Stop holds source side off
// - Run enables source side, commutates
// - Direction change reverses commutation immediately
// - Current trip leaves sink side braking
// - Low direction forward, high reverse
`timescale 1ns/1ns
`include "motor_drive_regs.svh"

module bldc_direct_pwm_drive_control #(
	parameter int SPEED_W = 8,
	parameter int CAP_W = 16,
	parameter int HALL_FILT_CYC = `HALL_FILT_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Hall comparator levels
	input wire logic hall_input_a,
	input wire logic hall_input_b,
	input wire logic hall_input_c,
	// Protection comparators
	input wire logic undervoltage_threshold,
	input wire logic thermal_limit,
	input wire logic current_sense_pin,
	// Phase gates
	output motor_drive_pkg::phase_drive_s phase_output,
	// Speed pulses
	output motor_drive_pkg::speed_pulse_s speed_pulse
);

	localparam int FC_W = $clog2(HALL_FILT_CYC + 1);

	// Refuse widths the fixed register layout cannot hold
	if (SPEED_W != 8 || CAP_W > 16 || CAP_W < 11 || HALL_FILT_CYC < 1) begin : g_chk
		$error("bldc_direct_pwm_drive_control: unsupported parameter");
	end

	// All state of the block
	typedef struct packed {
		logic [1:0] ack_pend;
		logic ack;
		logic [31:0] rdat;
		logic stop;
		logic rev;
		logic [SPEED_W-1:0] speed;
		logic [7:0] zero_thr;
		logic [7:0] full_thr;
		logic [CAP_W-1:0] cap_pf;
		logic [5:0] sync1;
		logic [5:0] sync2;
		logic [2:0] hall;
		logic [2:0][FC_W-1:0] fcnt;
		logic [31:0] acc;
		logic [7:0] pwm_cnt;
		motor_drive_pkg::fault_s fault;
		motor_drive_pkg::phase_drive_s drive;
		motor_drive_pkg::speed_pulse_s pulse;
	} state_s;

	state_s state_reg;
	state_s state_next;

	localparam logic [31:0] STEP = 32'(`OSC_STEP_PER_TICK * `PWM_STEPS);
	// Control reset value at its own width, so single bits can be picked
	localparam logic [1:0] RST_CTRL_V = `RST_CTRL;

	// Six-step table; reverse swaps source and sink
	function automatic motor_drive_pkg::phase_drive_s commutate(
		input logic [2:0] h, input logic rev);
		motor_drive_pkg::phase_drive_s d;
		d.src = 3'h0;
		d.snk = 3'h0;
		unique case (h)
			3'b101: begin
				d.src = 3'h1;
				d.snk = 3'h2;
			end
			3'b001: begin
				d.src = 3'h1;
				d.snk = 3'h4;
			end
			3'b011: begin
				d.src = 3'h2;
				d.snk = 3'h4;
			end
			3'b010: begin
				d.src = 3'h2;
				d.snk = 3'h1;
			end
			3'b110: begin
				d.src = 3'h4;
				d.snk = 3'h1;
			end
			3'b100: begin
				d.src = 3'h4;
				d.snk = 3'h2;
			end
			default: begin
				d.src = 3'h0;
				d.snk = 3'h0;
			end
		endcase
		if (rev) begin
			return '{src: d.snk, snk: d.src};
		end
		return d;
	endfunction : commutate

	// Byte-lane merge of a write
	function automatic logic [31:0] merge(
		input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	logic [31:0] rd_mux;
	logic [31:0] wr_val;
	logic [31:0] status_word;
	logic [31:0] thr_cyc;
	logic [31:0] acc_sum;
	logic tick;
	logic period_start;
	logic [7:0] duty;
	logic pwm_on;
	logic src_enable;
	motor_drive_pkg::phase_drive_s pattern;

	// Next-state logic
	always_comb begin
		state_next = state_reg;
		status_word = 32'h0;
		status_word[`ST_UV_BIT] = state_reg.fault.uv;
		status_word[`ST_OT_BIT] = state_reg.fault.ot;
		status_word[`ST_ILIM_BIT] = state_reg.fault.ilim;
		status_word[`ST_HALL_LSB +: 3] = state_reg.hall;
		status_word[`ST_FG1_BIT] = state_reg.pulse.single_rate;
		status_word[`ST_FG2_BIT] = state_reg.pulse.triple_rate;
		status_word[`ST_SRC_LSB +: 3] = state_reg.drive.src;
		status_word[`ST_SNK_LSB +: 3] = state_reg.drive.snk;

		// Read mux; unmapped offsets read zero
		rd_mux = 32'h0;
		unique case (wb_adr_i)
			`OFS_CTRL: begin
				rd_mux[`CTRL_STOP_BIT] = state_reg.stop;
				rd_mux[`CTRL_REV_BIT] = state_reg.rev;
			end
			`OFS_SPEED: rd_mux[SPEED_W-1:0] = state_reg.speed;
			`OFS_THRESH: begin
				rd_mux[`THR_ZERO_LSB +: 8] = state_reg.zero_thr;
				rd_mux[`THR_FULL_LSB +: 8] = state_reg.full_thr;
			end
			`OFS_CAP: rd_mux[CAP_W-1:0] = state_reg.cap_pf;
			`OFS_STATUS: rd_mux = status_word;
			default: rd_mux = 32'h0;
		endcase

		// Ack one cycle after the request; write lands on the ack edge
		state_next.ack = wb_cyc_i && wb_stb_i && !state_reg.ack;
		state_next.ack_pend = 2'h0;
		if (wb_cyc_i && wb_stb_i && !state_reg.ack) begin
			state_next.rdat = rd_mux;
		end
		wr_val = merge(rd_mux, wb_dat_i, wb_sel_i);
		if (wb_cyc_i && wb_stb_i && wb_we_i && state_reg.ack) begin
			unique case (wb_adr_i)
				`OFS_CTRL: begin
					state_next.stop = wr_val[`CTRL_STOP_BIT];
					state_next.rev = wr_val[`CTRL_REV_BIT];
				end
				`OFS_SPEED: state_next.speed = wr_val[SPEED_W-1:0];
				`OFS_THRESH: begin
					state_next.zero_thr = wr_val[`THR_ZERO_LSB +: 8];
					state_next.full_thr = wr_val[`THR_FULL_LSB +: 8];
				end
				`OFS_CAP: state_next.cap_pf = wr_val[CAP_W-1:0];
				default: state_next.ack_pend = 2'h0;
			endcase
		end

		// Two-stage synchronisers for all pins
		state_next.sync1 = {current_sense_pin, thermal_limit, undervoltage_threshold,
			hall_input_c, hall_input_b, hall_input_a};
		state_next.sync2 = state_reg.sync1;

		// Hall levels change only after a stable run of samples
		for (int i = 0; i < 3; i++) begin
			if (state_reg.sync2[i] == state_reg.hall[i]) begin
				state_next.fcnt[i] = '0;
			end else if (state_reg.fcnt[i] == FC_W'(HALL_FILT_CYC - 1)) begin
				state_next.fcnt[i] = '0;
				state_next.hall[i] = state_reg.sync2[i];
			end else begin
				state_next.fcnt[i] = state_reg.fcnt[i] + 1'b1;
			end
		end

		// Oscillator: period of 256 ticks tracks the capacitance
		thr_cyc = 32'(state_reg.cap_pf) * 32'(`OSC_NUM);
		acc_sum = state_reg.acc + STEP;
		tick = acc_sum >= thr_cyc;
		if (tick) begin
			state_next.acc = acc_sum - thr_cyc;
			state_next.pwm_cnt = state_reg.pwm_cnt + 8'h01;
		end else begin
			state_next.acc = acc_sum;
		end
		period_start = tick && state_reg.pwm_cnt == 8'hFF;

		// Duty from the speed command with zero and full clamps
		if (state_reg.speed <= state_reg.zero_thr) begin
			duty = 8'h00;
		end else if (state_reg.speed >= state_reg.full_thr) begin
			duty = 8'hFF;
		end else begin
			duty = state_reg.speed;
		end
		pwm_on = duty == 8'hFF || state_reg.pwm_cnt < duty;

		// Protection levels
		state_next.fault.uv = state_reg.sync2[3];
		state_next.fault.ot = state_reg.sync2[4];
		// Current trip latches until the next period, then retries
		if (state_reg.sync2[5]) begin
			state_next.fault.ilim = 1'b1;
		end else if (period_start) begin
			state_next.fault.ilim = 1'b0;
		end

		// Commutation follows direction without delay
		pattern = commutate(state_reg.hall, state_reg.rev);
		src_enable = pwm_on && !state_reg.stop && !state_reg.fault.uv
			&& !state_reg.fault.ot && !state_reg.fault.ilim
			&& !state_reg.sync2[5];
		state_next.drive.src = src_enable ? pattern.src : 3'h0;
		// Sink side keeps braking through a current trip
		state_next.drive.snk = state_reg.stop ? 3'h0 : pattern.snk;

		// Speed pulses
		state_next.pulse.single_rate = state_reg.hall[0];
		state_next.pulse.triple_rate = ^state_reg.hall;
	end

	// State register with synchronous reset
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state_reg <= '0;
			state_reg.stop <= RST_CTRL_V[`CTRL_STOP_BIT];
			state_reg.rev <= RST_CTRL_V[`CTRL_REV_BIT];
			state_reg.speed <= `RST_SPEED;
			state_reg.zero_thr <= `RST_ZERO;
			state_reg.full_thr <= `RST_FULL;
			state_reg.cap_pf <= CAP_W'(`RST_CAP_PF);
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from the state register
	assign wb_ack_o = state_reg.ack;
	assign wb_dat_o = state_reg.rdat;
	assign phase_output = state_reg.drive;
	assign speed_pulse = state_reg.pulse;

endmodule : bldc_direct_pwm_drive_control

/* File: tb/motor_side_model.sv */
// Hall sensor and protection comparator model of the motor side
`timescale 1ns/1ns
module motor_side_model (
	// Clock
	input wire logic mclk,
	// Commanded rotor state {c,b,a} and faults {uv,ot,isense}
	input wire logic [2:0] code,
	input wire logic [2:0] fault,
	// Comparator levels
	output logic hall_a,
	output logic hall_b,
	output logic hall_c,
	output logic uv,
	output logic ot,
	output logic isense
);
	// Levels change just after the edge, as real comparators are asynchronous
	always_ff @(posedge mclk) begin
		{hall_c, hall_b, hall_a} <= code;
		{uv, ot, isense} <= fault;
	end
endmodule : motor_side_model

/* File: tb/drive_checker_props.sv */
// Port-level assertions of the drive control block
`timescale 1ns/1ns
module drive_checker (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// Pins
	input wire logic undervoltage_threshold,
	input wire logic thermal_limit,
	input wire logic current_sense_pin,
	input motor_drive_pkg::phase_drive_s phase_output
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_uv_cut: assert property (undervoltage_threshold [*6] |-> phase_output.src == 3'h0)
		else $error("source on in undervoltage");
	a_hot_cut: assert property (thermal_limit [*6] |-> phase_output.src == 3'h0)
		else $error("source on when overheated");
	a_limit_cut: assert property (current_sense_pin [*6] |-> phase_output.src == 3'h0)
		else $error("source on at current limit");
	a_gate_onehot: assert property ($onehot0(phase_output.src) && $onehot0(phase_output.snk))
		else $error("more than one gate per side");
	a_no_shoot: assert property ((phase_output.src & phase_output.snk) == 3'h0)
		else $error("source and sink on same phase");
	a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> phase_output == 6'h00 && !wb_ack_o)
		else $error("outputs active after reset");
endmodule : drive_checker
bind bldc_direct_pwm_drive_control drive_checker u_chk (.mclk(mclk), .rst_b(rst_b),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.undervoltage_threshold(undervoltage_threshold), .thermal_limit(thermal_limit),
	.current_sense_pin(current_sense_pin), .phase_output(phase_output));

/* File: tb/bldc_direct_pwm_drive_control_test.sv */
// Self-checking bench of the drive control block
`timescale 1ns/1ns
module bldc_direct_pwm_drive_control_test;
	logic mclk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, q, ack_dat;
	logic [2:0] code = 3'h0, fault = 3'h0;
	logic ha, hb, hc, uv, ot, cs, ack;
	motor_drive_pkg::phase_drive_s ph;
	motor_drive_pkg::speed_pulse_s sp;
	int err_total = 0, total_checks = 0, cyc_cnt = 0, on_cnt;
	// Forward rows {hall c b a, src, snk}
	logic [8:0] rows [8] = '{9'b101_001_010, 9'b001_001_100, 9'b011_010_100,
		9'b010_010_001, 9'b110_100_001, 9'b100_100_010, 9'b000_000_000, 9'b111_000_000};
	motor_side_model u_side (.mclk(mclk), .code(code), .fault(fault), .hall_a(ha),
		.hall_b(hb), .hall_c(hc), .uv(uv), .ot(ot), .isense(cs));
	bldc_direct_pwm_drive_control #(.HALL_FILT_CYC(2)) DUT (.mclk(mclk), .rst_b(rst_b),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(dat), .wb_dat_o(ack_dat), .wb_ack_o(ack), .hall_input_a(ha),
		.hall_input_b(hb), .hall_input_c(hc), .undervoltage_threshold(uv),
		.thermal_limit(ot), .current_sense_pin(cs), .phase_output(ph), .speed_pulse(sp));
	initial forever #20 mclk = ~mclk;
	// Classic single cycle, held until ack is sampled
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
		// Look at ack mid-cycle, where it has settled, then pass its edge
		do @(negedge mclk); while (ack !== 1'b1);
		q = ack_dat;
		@(posedge mclk);
		{cyc, stb} <= 2'b00;
	endtask : bus
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task give_verdict;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict
	// Hang guard
	always @(posedge mclk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			err_total++;
			give_verdict;
		end
	end
	initial begin
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		bus(0, 8'h00, 0); chk("ctrl", q, 32'h3);
		bus(0, 8'h08, 0); chk("thresh", q, 32'hF010);
		bus(0, 8'h0C, 0); chk("cap", q, 32'h514);
		bus(1, 8'h20, 32'hFFFFFFFF); bus(0, 8'h20, 0); chk("unmapped", q, 0);
		bus(1, 8'h04, 32'hFF);
		// Commutation table, direction changed only while stopped
		for (int r = 0; r < 2; r++) for (int i = 0; i < 8; i++) begin
			code <= rows[i][8:6];
			bus(1, 8'h00, {30'h0, r[0], 1'b1});
			bus(1, 8'h00, {30'h0, r[0], 1'b0});
			repeat (12) @(posedge mclk);
			chk("phase", ph, r ? {rows[i][2:0], rows[i][5:3]} : rows[i][5:0]);
			chk("pulse", sp, {code[0], ^code});
		end
		code <= 3'b101;
		bus(1, 8'h00, 32'h0);
		bus(1, 8'h00, 32'h2); repeat (4) @(posedge mclk);
		chk("reversal", ph, 6'b010_001);
		bus(1, 8'h00, 32'h0); repeat (4) @(posedge mclk);
		// Each protection input cuts only the source side
		for (int k = 0; k < 3; k++) begin
			fault <= 3'h1 << k; repeat (8) @(posedge mclk);
			chk("fault", ph, 6'b000_010);
			fault <= 3'h0; repeat (700) @(posedge mclk);
			chk("recover", ph, 6'b001_010);
		end
		bus(1, 8'h04, 32'h10); repeat (700) @(posedge mclk);
		chk("zero duty", ph, 6'b000_010);
		bus(1, 8'h04, 32'h80); repeat (700) @(posedge mclk);
		on_cnt = 0;
		repeat (1281) begin
			@(posedge mclk);
			on_cnt += (ph.src === 3'b001);
		end
		chk("half duty", on_cnt >= 600 && on_cnt <= 680, 1);
		bus(1, 8'h00, 32'h1); repeat (4) @(posedge mclk);
		chk("stop", ph, 6'h00);
		give_verdict;
	end
endmodule : bldc_direct_pwm_drive_control_test
